/* core/epa_pkg.sv */
// constants and types for the prom programming controller
package epa_pkg;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned ADDR_W        = 13;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned LOW_W         = 8;
  localparam int unsigned HIGH_W        = 5;
  localparam int unsigned PULSE_US      = 200;
  localparam int unsigned OVER_MULT     = 4;
  localparam int unsigned MAX_PULSES    = 10;
  localparam int unsigned FINAL_MS      = 8;
  localparam int unsigned SETUP_US      = 1;
  localparam int unsigned VERIFY_US     = 2;
  localparam int unsigned POWER_MS      = 20;
  localparam int unsigned READ_NS       = 55;
  localparam int unsigned FLOAT_NS      = 55;
  localparam int unsigned PULSE_CYC     = PULSE_US * (CLK_HZ / 1000000);
  localparam int unsigned FINAL_CYC     = FINAL_MS * (CLK_HZ / 1000);
  localparam int unsigned SETUP_CYC     = SETUP_US * (CLK_HZ / 1000000);
  localparam int unsigned VERIFY_CYC    = VERIFY_US * (CLK_HZ / 1000000);
  localparam int unsigned POWER_CYC     = POWER_MS * (CLK_HZ / 1000);
  localparam int unsigned READ_CYC      = (READ_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned FLOAT_CYC     = (FLOAT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W         = 32;
  typedef enum logic [1:0] {EPA_OP_READ, EPA_OP_PROGRAM, EPA_OP_BLANK} epa_op_t;
  typedef enum logic [1:0] {EPA_OK, EPA_REJECT, EPA_NOT_BLANK} epa_result_t;
endpackage

/* core/epa_prom_host.sv */
// host controller that reads, blank checks and programs the prom
`timescale 1ns/1ps
`default_nettype none
module epa_prom_host #(
  parameter int unsigned PULSE_CYCLES  = epa_pkg::PULSE_CYC,
  parameter int unsigned FINAL_CYCLES  = epa_pkg::FINAL_CYC,
  parameter int unsigned POWER_CYCLES  = epa_pkg::POWER_CYC
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          clk_en_i,
  input  wire logic                          req_valid_i,
  output logic                               req_ready_o,
  input  wire epa_pkg::epa_op_t              req_op_i,
  input  wire logic [epa_pkg::ADDR_W-1:0]    req_addr_i,
  input  wire logic [epa_pkg::ADDR_W-1:0]    req_last_i,
  output logic                               wr_data_req_o,
  output logic [epa_pkg::ADDR_W-1:0]         wr_data_addr_o,
  input  wire logic [epa_pkg::DATA_W-1:0]    wr_data_i,
  output logic                               done_o,
  output epa_pkg::epa_result_t               result_o,
  output logic [epa_pkg::DATA_W-1:0]         rd_data_o,
  output logic [epa_pkg::ADDR_W-1:0]         fail_addr_o,
  output logic [epa_pkg::ADDR_W-1:0]         pin_addr_o,
  output logic                               chip_select_n_o,
  output logic                               programming_supply_o,
  output logic                               ctl_low_a_o,
  output logic                               ctl_low_b_o,
  output logic                               upper_address_latch_o,
  output logic                               program_strobe_n_o,
  output logic                               verify_strobe_n_o,
  output logic [epa_pkg::DATA_W-1:0]         data_o,
  output logic                               data_oe_o,
  input  wire logic [epa_pkg::DATA_W-1:0]    data_i
);
  import epa_pkg::*;

  // refuse timings that the counters cannot serve
  if (PULSE_CYCLES < 1 || FINAL_CYCLES < 1 || POWER_CYCLES < 1) begin : g_short_timing
    $error("epa_prom_host: timing parameters must be at least one cycle");
  end
  if (1.0 * OVER_MULT * MAX_PULSES * PULSE_CYCLES >= 2.0**CNT_W ||
      1.0 * FINAL_CYCLES >= 2.0**CNT_W || 1.0 * POWER_CYCLES >= 2.0**CNT_W) begin : g_long_timing
    $error("epa_prom_host: pulse lengths overflow the cycle counter");
  end
  if (LOW_W + HIGH_W != ADDR_W || MAX_PULSES > 15) begin : g_bad_split
    $error("epa_prom_host: address split or pulse limit unsupported");
  end

  typedef enum logic [4:0] {
    ST_IDLE, ST_RD_WAIT, ST_RD_FLOAT, ST_PWR_UP, ST_LAT_SETUP, ST_LAT_PULSE, ST_LAT_HOLD,
    ST_FETCH, ST_DSETUP, ST_PGM, ST_DHOLD, ST_VSETUP, ST_VFY, ST_VHOLD, ST_NEXT, ST_PWR_DOWN
  } epa_state_t;

  epa_state_t              state;
  epa_op_t                 op;
  logic [CNT_W-1:0]        cnt;
  logic [CNT_W-1:0]        pgm_len;
  logic [ADDR_W-1:0]       addr;
  logic [ADDR_W-1:0]       last;
  logic [DATA_W-1:0]       wdata;
  logic [3:0]              tries;
  logic                    over_phase;
  logic                    final_phase;
  logic                    failed;
  logic [DATA_W-1:0]       din_meta;
  logic [DATA_W-1:0]       din_sync;
  logic                    cnt_done;

  // one down-counter times every wait
  assign cnt_done       = (cnt == '0);
  assign req_ready_o    = (state == ST_IDLE);
  assign wr_data_req_o  = (state == ST_FETCH);
  assign wr_data_addr_o = addr;

  // pins from the device pass two flops
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      din_meta <= '0;
      din_sync <= '0;
    end else if (clk_en_i) begin
      din_meta <= data_i;
      din_sync <= din_meta;
    end
  end

  // one state walk per byte: setup, pulse, hold, verify
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state       <= ST_IDLE;
      op          <= EPA_OP_READ;
      cnt         <= '0;
      pgm_len     <= '0;
      addr        <= '0;
      last        <= '0;
      wdata       <= '0;
      tries       <= '0;
      over_phase  <= 1'b0;
      final_phase <= 1'b0;
      failed      <= 1'b0;
      done_o      <= 1'b0;
      result_o    <= EPA_OK;
      rd_data_o   <= '0;
      fail_addr_o <= '0;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      if (!cnt_done)
        cnt <= cnt - 1'b1;
      case (state)
        ST_IDLE: begin
          if (req_valid_i) begin
            op     <= req_op_i;
            addr   <= req_addr_i;
            last   <= req_last_i;
            failed <= 1'b0;
            if (req_op_i == EPA_OP_READ) begin
              // two sync stages added to access time
              cnt   <= CNT_W'(READ_CYC + 2);
              state <= ST_RD_WAIT;
            end else begin
              cnt   <= CNT_W'(POWER_CYCLES);
              state <= ST_PWR_UP;
            end
          end
        end
        ST_RD_WAIT: if (cnt_done) begin
          rd_data_o <= din_sync;
          cnt       <= CNT_W'(FLOAT_CYC);
          state     <= ST_RD_FLOAT;
        end
        ST_RD_FLOAT: if (cnt_done) begin
          result_o <= EPA_OK;
          done_o   <= 1'b1;
          state    <= ST_IDLE;
        end
        ST_PWR_UP: if (cnt_done) begin
          cnt   <= CNT_W'(SETUP_CYC);
          state <= ST_LAT_SETUP;
        end
        ST_LAT_SETUP: if (cnt_done) begin
          cnt   <= CNT_W'(SETUP_CYC);
          state <= ST_LAT_PULSE;
        end
        ST_LAT_PULSE: if (cnt_done) begin
          cnt   <= CNT_W'(SETUP_CYC);
          state <= ST_LAT_HOLD;
        end
        ST_LAT_HOLD: if (cnt_done) begin
          tries       <= '0;
          over_phase  <= 1'b0;
          final_phase <= 1'b0;
          pgm_len     <= '0;
          cnt         <= CNT_W'(SETUP_CYC);
          state       <= (op == EPA_OP_BLANK) ? ST_VSETUP : ST_FETCH;
        end
        ST_FETCH: begin
          // data word for this address arrives in this cycle
          wdata <= wr_data_i;
          cnt   <= CNT_W'(SETUP_CYC);
          state <= ST_DSETUP;
        end
        ST_DSETUP: if (cnt_done) begin
          // loads are one short: the strobe stays low for cnt+1 cycles
          if (final_phase)
            cnt <= CNT_W'(FINAL_CYCLES - 1);
          else if (over_phase)
            cnt <= CNT_W'(OVER_MULT) * pgm_len - CNT_W'(1);
          else begin
            cnt     <= CNT_W'(PULSE_CYCLES - 1);
            pgm_len <= pgm_len + CNT_W'(PULSE_CYCLES);
            tries   <= tries + 4'h1;
          end
          state <= ST_PGM;
        end
        ST_PGM: if (cnt_done) begin
          cnt   <= CNT_W'(SETUP_CYC);
          state <= ST_DHOLD;
        end
        ST_DHOLD: if (cnt_done) begin
          cnt   <= CNT_W'(SETUP_CYC);
          state <= over_phase ? ST_NEXT : ST_VSETUP;
        end
        ST_VSETUP: if (cnt_done) begin
          // two extra cycles cover the input synchroniser
          cnt   <= CNT_W'(VERIFY_CYC + 2);
          state <= ST_VFY;
        end
        ST_VFY: if (cnt_done) begin
          cnt   <= CNT_W'(SETUP_CYC + 2);
          state <= ST_VHOLD;
          if (op == EPA_OP_BLANK) begin
            if (din_sync != '0) begin
              failed      <= 1'b1;
              fail_addr_o <= addr;
            end
            state <= ST_NEXT;
          end else if (din_sync == wdata) begin
            over_phase <= !final_phase;
            state      <= final_phase ? ST_NEXT : ST_VHOLD;
          end else if (final_phase) begin
            failed      <= 1'b1;
            fail_addr_o <= addr;
            state       <= ST_PWR_DOWN;
            cnt         <= CNT_W'(POWER_CYCLES);
          // tenth pulse failed: one long pulse, then a last verify
          end else if (tries == 4'(MAX_PULSES))
            final_phase <= 1'b1;
        end
        ST_VHOLD: if (cnt_done) begin
          cnt   <= CNT_W'(SETUP_CYC);
          state <= ST_DSETUP;
        end
        ST_NEXT: if (cnt_done) begin
          if (failed && op == EPA_OP_BLANK || addr == last) begin
            cnt   <= CNT_W'(POWER_CYCLES);
            state <= ST_PWR_DOWN;
          end else begin
            addr        <= addr + 1'b1;
            tries       <= '0;
            over_phase  <= 1'b0;
            final_phase <= 1'b0;
            pgm_len     <= '0;
            cnt         <= CNT_W'(SETUP_CYC);
            // end of a 256-byte block: relatch the upper bits
            if (addr[LOW_W-1:0] == '1)
              state <= ST_LAT_SETUP;
            else
              state <= (op == EPA_OP_BLANK) ? ST_VSETUP : ST_FETCH;
          end
        end
        ST_PWR_DOWN: if (cnt_done) begin
          // result names why the run stopped
          result_o <= !failed ? EPA_OK : (op == EPA_OP_BLANK ? EPA_NOT_BLANK : EPA_REJECT);
          done_o   <= 1'b1;
          state    <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // select, supply and the two program-low pins
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      chip_select_n_o      <= 1'b1;
      programming_supply_o <= 1'b0;
      ctl_low_a_o          <= 1'b0;
      ctl_low_b_o          <= 1'b0;
    end else if (clk_en_i) begin
      chip_select_n_o      <= !(state == ST_RD_WAIT);
      // supply rises at the end of the power-up delay and drops at the end of the power-down delay
      programming_supply_o <= !(state == ST_IDLE || state == ST_RD_WAIT || state == ST_RD_FLOAT ||
                                (state == ST_PWR_UP && cnt > CNT_W'(1)) ||
                                (state == ST_PWR_DOWN && cnt < CNT_W'(2)));
      // both pins sit at the program low level in every mode
      ctl_low_a_o          <= 1'b0;
      ctl_low_b_o          <= 1'b0;
    end
  end

  // address pins: full address for reads, split halves when programming
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pin_addr_o <= '0;
    end else if (clk_en_i) begin
      if (state == ST_RD_WAIT || state == ST_IDLE)
        pin_addr_o <= (state == ST_IDLE) ? req_addr_i : addr;
      else if (state == ST_LAT_SETUP || state == ST_LAT_PULSE || state == ST_LAT_HOLD)
        pin_addr_o <= {{(ADDR_W-HIGH_W){1'b0}}, addr[ADDR_W-1:LOW_W]};
      else
        pin_addr_o <= {{HIGH_W{1'b0}}, addr[LOW_W-1:0]};
    end
  end

  // latch and strobe pins
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      upper_address_latch_o <= 1'b0;
      program_strobe_n_o    <= 1'b1;
      verify_strobe_n_o     <= 1'b1;
    end else if (clk_en_i) begin
      upper_address_latch_o <= (state == ST_LAT_PULSE);
      // only one strobe state at a time
      program_strobe_n_o    <= !(state == ST_PGM);
      verify_strobe_n_o     <= !(state == ST_VFY);
    end
  end

  // data pins
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      data_o    <= '0;
      data_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      // driven only around a program pulse, never in verify or inhibit
      data_o    <= wdata;
      data_oe_o <= (state == ST_DSETUP || state == ST_PGM || state == ST_DHOLD) &&
                   op == EPA_OP_PROGRAM;
    end
  end
endmodule
`default_nettype wire

/* verif/epa_prom_model.sv */
// behavioural prom device on the host pins
`timescale 1ns/1ps
`default_nettype none
module epa_prom_model (
  input  wire logic        clk_i,
  input  wire logic [12:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        vpp_i,
  input  wire logic        low_a_i,
  input  wire logic        low_b_i,
  input  wire logic        lat_i,
  input  wire logic        pgm_n_i,
  input  wire logic        vfy_n_i,
  input  wire logic [7:0]  host_d_i,
  input  wire logic        host_oe_i,
  output wire logic [7:0]  bus_o
);
  logic [7:0]  mem [8192] = '{default: 8'h00};
  int          tries [8192];
  int          lens [$];
  int          need = 1;
  int          cnt = 0;
  logic [4:0]  upper = 5'h00;
  logic [7:0]  last = 8'h00;
  logic [7:0]  pd = 8'h00;
  logic        prog, drive, standby;
  logic [12:0] pa;
  assign prog = vpp_i && !low_a_i && !low_b_i;
  assign pa = {upper, addr_i[7:0]};
  assign standby = cs_n_i && !prog;
  assign drive = prog ? !vfy_n_i && pgm_n_i : !cs_n_i;
  // released bus shows the inverse of its last value
  assign bus_o = host_oe_i ? host_d_i : !drive ? ~last : prog ? mem[pa] : mem[addr_i];
  always @(posedge lat_i) if (prog) upper = addr_i[4:0];
  always @(posedge clk_i) begin
    if (host_oe_i || drive) last <= bus_o;
    if (prog && !pgm_n_i) begin
      cnt <= cnt + 1;
      pd <= host_oe_i ? host_d_i : ~host_d_i;
    end else if (cnt > 0) begin
      lens.push_back(cnt);
      cnt <= 0;
      tries[pa] = tries[pa] + 1;
      if (tries[pa] >= need) mem[pa] <= pd;
    end
  end
endmodule
`default_nettype wire

/* verif/epa_prom_host_properties.sv */
// pin-level assertions for the prom host controller
`timescale 1ns/1ps
`default_nettype none
module epa_prom_host_properties #(
  parameter int unsigned PULSE_CYCLES = epa_pkg::PULSE_CYC,
  parameter int unsigned POWER_CYCLES = epa_pkg::POWER_CYC
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        req_valid_i,
  input wire logic        req_ready_o,
  input wire logic        done_o,
  input wire logic [12:0] pin_addr_o,
  input wire logic        chip_select_n_o,
  input wire logic        programming_supply_o,
  input wire logic        ctl_low_a_o,
  input wire logic        ctl_low_b_o,
  input wire logic        upper_address_latch_o,
  input wire logic        program_strobe_n_o,
  input wire logic        verify_strobe_n_o,
  input wire logic [7:0]  data_o,
  input wire logic        data_oe_o
);
  int unsigned plen;
  int unsigned vlen;
  int unsigned since_req;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || program_strobe_n_o) plen <= 0;
    else plen <= plen + 1;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || verify_strobe_n_o) vlen <= 0;
    else vlen <= vlen + 1;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || (req_valid_i && req_ready_o)) since_req <= 0;
    else since_req <= since_req + 1;
  end
  strobe_excl_a: assert property (!(!program_strobe_n_o && !verify_strobe_n_o))
    else $error("both strobes low");
  mode_entry_a: assert property (!program_strobe_n_o || !verify_strobe_n_o || upper_address_latch_o
    |-> programming_supply_o && !ctl_low_a_o && !ctl_low_b_o) else $error("strobe outside programming");
  read_mode_a: assert property (!chip_select_n_o |-> !programming_supply_o)
    else $error("select during programming");
  pgm_data_a: assert property (!program_strobe_n_o |-> data_oe_o)
    else $error("program pulse without data");
  vfy_release_a: assert property (!verify_strobe_n_o |-> !data_oe_o)
    else $error("data driven during verify");
  pgm_hold_a: assert property (!program_strobe_n_o && !$past(program_strobe_n_o)
    |-> $stable(data_o) && $stable(pin_addr_o)) else $error("data or address moved in pulse");
  vfy_width_a: assert property ($rose(verify_strobe_n_o) |-> vlen >= epa_pkg::VERIFY_CYC)
    else $error("verify pulse too short");
  supply_delay_a: assert property ($rose(programming_supply_o) |-> since_req >= POWER_CYCLES)
    else $error("supply raised before power delay");
  pulse_width_a: assert property ($rose(program_strobe_n_o) |-> plen >= PULSE_CYCLES)
    else $error("program pulse too short");
  latch_addr_a: assert property ($rose(upper_address_latch_o) |-> $stable(pin_addr_o) ##1 $stable(pin_addr_o))
    else $error("address moved around latch");
  cover property ($rose(upper_address_latch_o));
  cover property ($fell(verify_strobe_n_o));
  cover property (done_o);
endmodule
bind epa_prom_host epa_prom_host_properties #(.PULSE_CYCLES(PULSE_CYCLES), .POWER_CYCLES(POWER_CYCLES))
  u_props (.ref_clk_i, .rst_b_i, .req_valid_i, .req_ready_o,
  .done_o, .pin_addr_o, .chip_select_n_o, .programming_supply_o, .ctl_low_a_o, .ctl_low_b_o,
  .upper_address_latch_o, .program_strobe_n_o, .verify_strobe_n_o, .data_o, .data_oe_o);
`default_nettype wire

/* verif/epa_prom_host_bench.sv */
// self-checking bench for the prom host controller
`timescale 1ns/1ps
`default_nettype none
module epa_prom_host_bench;
  import epa_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        clk_en_i = 1'b1;
  logic        req_valid_i = 1'b0;
  epa_op_t     req_op_i = EPA_OP_READ;
  logic [12:0] req_addr_i = 13'h0000;
  logic [12:0] req_last_i = 13'h0000;
  logic [12:0] wr_data_addr_o, fail_addr_o, pin_addr_o;
  logic [7:0]  wr_data_i, rd_data_o, data_o, data_i;
  logic        req_ready_o, wr_data_req_o, done_o, chip_select_n_o, programming_supply_o, ctl_low_a_o;
  logic        ctl_low_b_o, upper_address_latch_o, program_strobe_n_o, verify_strobe_n_o, data_oe_o;
  epa_result_t result_o;
  int          n_errors = 0;
  int          n_compared = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  assign wr_data_i = wr_data_req_o ? wr_data_addr_o[7:0] ^ 8'hA5 : 8'h00;
  epa_prom_host #(.PULSE_CYCLES(20), .FINAL_CYCLES(40), .POWER_CYCLES(30)) uut (.ref_clk_i, .rst_b_i,
    .clk_en_i, .req_valid_i, .req_ready_o, .req_op_i, .req_addr_i, .req_last_i, .wr_data_req_o,
    .wr_data_addr_o, .wr_data_i, .done_o, .result_o, .rd_data_o, .fail_addr_o, .pin_addr_o,
    .chip_select_n_o, .programming_supply_o, .ctl_low_a_o, .ctl_low_b_o, .upper_address_latch_o,
    .program_strobe_n_o, .verify_strobe_n_o, .data_o, .data_oe_o, .data_i);
  epa_prom_model dev (.clk_i(ref_clk_i), .addr_i(pin_addr_o), .cs_n_i(chip_select_n_o),
    .vpp_i(programming_supply_o), .low_a_i(ctl_low_a_o), .low_b_i(ctl_low_b_o), .lat_i(upper_address_latch_o),
    .pgm_n_i(program_strobe_n_o), .vfy_n_i(verify_strobe_n_o), .host_d_i(data_o), .host_oe_i(data_oe_o),
    .bus_o(data_i));
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("%0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic run(input epa_op_t op, input logic [12:0] first, input logic [12:0] last);
    int i;
    @(negedge ref_clk_i);
    req_op_i = op;
    req_addr_i = first;
    req_last_i = last;
    req_valid_i = 1'b1;
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    chk(16'h0000, 16'(req_ready_o));
    for (i = 0; i < 9000 && done_o !== 1'b1; i++) @(negedge ref_clk_i);
    if (i == 9000) begin
      n_errors++;
      report_and_stop;
    end
  endtask
  task automatic t_read;
    dev.mem[13'h1ABC] = 8'h3C;
    run(EPA_OP_READ, 13'h1ABC, 13'h1ABC);
    chk(16'h003C, rd_data_o);
    chk(EPA_OK, result_o);
    $display("read test done");
  endtask
  task automatic t_freeze;
    int i;
    dev.mem[13'h0055] = 8'hC3;
    @(negedge ref_clk_i);
    req_op_i = EPA_OP_READ;
    req_addr_i = 13'h0055;
    req_last_i = 13'h0055;
    req_valid_i = 1'b1;
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    clk_en_i = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    chk(16'h0001, 16'(chip_select_n_o));
    chk(16'h0000, 16'(done_o));
    clk_en_i = 1'b1;
    for (i = 0; i < 100 && done_o !== 1'b1; i++) @(negedge ref_clk_i);
    if (i == 100) begin
      n_errors++;
      report_and_stop;
    end
    chk(16'h00C3, rd_data_o);
    $display("freeze test done");
  endtask
  task automatic t_blank;
    run(EPA_OP_BLANK, 13'h00FE, 13'h0103);
    chk(EPA_OK, result_o);
    dev.mem[13'h0101] = 8'h10;
    run(EPA_OP_BLANK, 13'h00FE, 13'h0103);
    chk(EPA_NOT_BLANK, result_o);
    chk(13'h0101, fail_addr_o);
    $display("blank test done");
  endtask
  task automatic t_prog;
    dev.need = 3;
    dev.lens.delete();
    run(EPA_OP_PROGRAM, 13'h01FF, 13'h0200);
    chk(EPA_OK, result_o);
    chk(16'h005A, dev.mem[13'h01FF]);
    chk(16'h00A5, dev.mem[13'h0200]);
    chk(16'd8, 16'(dev.lens.size()));
    chk(16'd20, 16'(dev.lens[0]));
    chk(16'd240, 16'(dev.lens[3]));
    $display("program test done");
  endtask
  task automatic t_reject;
    dev.need = 20;
    dev.lens.delete();
    run(EPA_OP_PROGRAM, 13'h0300, 13'h0301);
    chk(EPA_REJECT, result_o);
    chk(13'h0300, fail_addr_o);
    chk(16'd11, 16'(dev.lens.size()));
    chk(16'd40, 16'(dev.lens[10]));
    $display("reject test done");
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    t_read;
    t_freeze;
    t_blank;
    t_prog;
    t_reject;
    report_and_stop;
  end
endmodule
`default_nettype wire
